/* core/output_serializer_pkg.sv */
/*
 * Constants shared by the output serializer: register offsets, control field
 * positions, reset values and the encodings of the rate and role settings.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package output_serializer_pkg;
	localparam int WORD_MAX = 10;
	localparam int PAR_IN = 6;
	localparam int TRI_MAX = 4;
	localparam int CASC_BITS = 4;
	localparam int CNT_W = 4;

	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;

	localparam int CTRL_RATE_BIT = 0;
	localparam int CTRL_TRATE_LSB = 1;
	localparam int CTRL_WIDTH_LSB = 3;
	localparam int CTRL_TWIDTH_LSB = 7;
	localparam int CTRL_ROLE_BIT = 10;
	localparam int CTRL_INIT_D_BIT = 11;
	localparam int CTRL_INIT_T_BIT = 12;
	localparam int CTRL_FORCE_D_BIT = 13;
	localparam int CTRL_FORCE_T_BIT = 14;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0225;
	localparam logic [31:0] CTRL_MASK = 32'h0000_7FFF;

	localparam int ST_DATA_BIT = 0;
	localparam int ST_TRI_BIT = 1;
	localparam int ST_FORCE_BIT = 2;
	localparam int ST_CFG_ERR_BIT = 3;
	localparam int ST_ROLE_BIT = 4;

	localparam logic RATE_SDR = 1'b0;
	localparam logic RATE_DDR = 1'b1;
	localparam logic [1:0] TRATE_BUF = 2'h0;
	localparam logic [1:0] TRATE_SDR = 2'h1;
	localparam logic [1:0] TRATE_DDR = 2'h2;
	localparam logic ROLE_MASTER = 1'b0;
	localparam logic ROLE_SLAVE = 1'b1;

	localparam logic DATA_OUT_RESET = 1'b0;
	localparam logic TRISTATE_OUT_RESET = 1'b0;
endpackage : output_serializer_pkg

/* core/bit_tick.sv */
/*
 * Bit-edge enable for the serializers. Each clk_i cycle stands for one fast
 * clock edge; single-rate mode uses only every other one (the rising edges).
 * Assumes the same clock and synchronous reset as the serializer.
 */
`timescale 1ns/100ps
module bit_tick (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic double_rate_i,
	output logic data_tick_o,
	output logic rise_tick_o
);
	logic phase;
	logic next_phase;

	always_comb begin
		next_phase = ~phase;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase <= 1'b0;
		end else begin
			phase <= next_phase;
		end
	end

	// Rising fast edges only
	assign rise_tick_o = phase;
	assign data_tick_o = double_rate_i | phase;
endmodule : bit_tick

/* core/word_shifter.sv */
/*
 * One parallel-to-serial converter with hold register, force and bypass.
 * Assumes load_i marks a captured word and tick_i marks each bit edge.
 */
`timescale 1ns/100ps
module word_shifter #(
	parameter int WIDTH = 10,
	parameter logic RESET_LEVEL = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] width_i,
	input wire logic [WIDTH-1:0] word_i,
	input wire logic load_i,
	input wire logic tick_i,
	input wire logic enable_i,
	input wire logic bypass_i,
	input wire logic force_i,
	input wire logic force_level_i,
	input wire logic init_level_i,
	output logic bit_o
);
	typedef enum logic [2:0] {
		ST_INIT = 3'b001,
		ST_RUN = 3'b010,
		ST_FORCE = 3'b100
	} shift_state_t;

	shift_state_t state, next_state;
	logic [WIDTH-1:0] shreg, next_shreg, hold, next_hold;
	logic [3:0] cnt, next_cnt;
	logic next_bit;

	always_comb begin
		next_state = state;
		next_shreg = shreg;
		next_hold = load_i ? word_i : hold;
		next_cnt = cnt;
		next_bit = bit_o;
		case (state)
			ST_INIT: begin
				next_bit = init_level_i;
				if (load_i) begin
					next_shreg = word_i;
					next_cnt = 4'h0;
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (tick_i && enable_i) begin
					next_bit = shreg[0];
					if (cnt == width_i - 4'h1) begin
						next_shreg = load_i ? word_i : hold;
						next_cnt = 4'h0;
					end else begin
						next_shreg = shreg >> 1;
						next_cnt = cnt + 4'h1;
					end
				end
			end
			ST_FORCE: begin
				next_state = ST_INIT;
			end
			default: begin
				next_state = ST_INIT;
			end
		endcase
		if (bypass_i) begin
			next_bit = word_i[0];
		end
		if (force_i) begin
			next_state = ST_FORCE;
			next_bit = force_level_i;
			next_cnt = 4'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_INIT;
			shreg <= '0;
			hold <= '0;
			cnt <= 4'h0;
			bit_o <= RESET_LEVEL;
		end else begin
			state <= next_state;
			shreg <= next_shreg;
			hold <= next_hold;
			cnt <= next_cnt;
			bit_o <= next_bit;
		end
	end
endmodule : word_shifter

/* core/output_serializer.sv */
/*
 * Output serializer: parallel data and 3-state words to serial streams for a
 * pad, with master/slave cascading and a Wishbone control/status register.
 * Assumes clk_i is the fast bit clock (one cycle per fast edge), that the
 * divided clock arrives as a one-cycle pulse on the same clock, and that all
 * fabric inputs are synchronous to clk_i.
 */
// The implementer's own choices: the Wishbone interface to the registers and the address map.
// Overview of operation
// - Parallel word is 2 to 6 bits, up to 10 when cascaded.
// - Serial data output changes only while data shift enable is high.
// - Force puts outputs to force levels; reset wins over force.
// - Force drives data and 3-state outputs to their force levels, default 0.
// - One to four 3-state bits; no 3-state path when cascaded (buffer mode on a master still follows the pin here).
// - Serial 3-state output changes only while 3-state shift enable is high (buffer mode here follows the pin with it low too).
// - Widths 7, 8, 10 need master plus slave, slave cascade out to master.
// - Slave takes only inputs three to six and passes them on cascade.
// - First parallel input bit is sent first.
// - 3-state serializer is at most four bits, never widened.
// - Double rate changes data every fast edge; single rate on rising only.
// - 3-state modes: double rate, single rate, buffer.
// - After configuration outputs start at their initial levels, default 0.
// - Role setting selects master or slave, master by default.
`timescale 1ns/100ps
module output_serializer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic divided_clock_i,
	input wire logic [5:0] parallel_data_in_i,
	input wire logic [3:0] parallel_tristate_in_i,
	input wire logic data_shift_enable_i,
	input wire logic tristate_shift_enable_i,
	input wire logic output_force_i,
	input wire logic [3:0] cascade_in_i,
	output logic [3:0] cascade_out_o,
	output logic serial_data_out_o,
	output logic serial_tristate_out_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	logic [31:0] ctrl, next_ctrl;
	logic [31:0] next_dat;
	logic next_ack;
	logic [5:0] data_q, next_data_q;
	logic [3:0] tri_q, next_tri_q;
	logic load_q, next_load_q;
	logic [3:0] next_cascade;
	logic data_rate;
	logic [1:0] tri_rate;
	logic [3:0] data_width;
	logic [3:0] tri_width;
	logic role;
	logic data_tick, rise_tick, tri_tick;
	logic master_load, tri_load;
	logic [9:0] data_word;
	logic [3:0] tri_word;
	logic cfg_err;
	logic bus_req;

	function automatic logic cfg_illegal(input logic ddr, input logic [3:0] w,
		input logic [1:0] tr, input logic [3:0] tw);
		logic bad_d;
		logic bad_t;
		bad_d = ddr ? !(w == 4'h4 || w == 4'h6 || w == 4'h8 || w == 4'hA)
			: (w < 4'h2 || w > 4'h8);
		bad_t = (tr == output_serializer_pkg::TRATE_DDR) ? !(tw == 4'h2 || tw == 4'h4)
			: (tr == output_serializer_pkg::TRATE_BUF) ? (tw != 4'h1)
			: !(tw == 4'h1 || tw == 4'h2 || tw == 4'h4);
		cfg_illegal = bad_d | bad_t | (tr == 2'h3);
	endfunction : cfg_illegal

	assign data_rate = ctrl[output_serializer_pkg::CTRL_RATE_BIT];
	assign tri_rate = ctrl[output_serializer_pkg::CTRL_TRATE_LSB +: 2];
	assign data_width = ctrl[output_serializer_pkg::CTRL_WIDTH_LSB +: 4];
	assign tri_width = {1'b0, ctrl[output_serializer_pkg::CTRL_TWIDTH_LSB +: 3]};
	assign role = ctrl[output_serializer_pkg::CTRL_ROLE_BIT];
	assign cfg_err = cfg_illegal(data_rate, data_width, tri_rate, tri_width);
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// Register bus: one-cycle answer, unmapped reads return zero
	always_comb begin
		next_ctrl = ctrl;
		next_ack = bus_req;
		next_dat = 32'h0000_0000;
		if (bus_req && wb_we_i && wb_adr_i == output_serializer_pkg::CTRL_ADDR) begin
			if (wb_sel_i[0]) begin
				next_ctrl[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				next_ctrl[15:8] = wb_dat_i[15:8];
			end
			next_ctrl = next_ctrl & output_serializer_pkg::CTRL_MASK;
		end
		if (bus_req && !wb_we_i) begin
			if (wb_adr_i == output_serializer_pkg::CTRL_ADDR) begin
				next_dat = ctrl;
			end else if (wb_adr_i == output_serializer_pkg::STATUS_ADDR) begin
				next_dat[output_serializer_pkg::ST_DATA_BIT] = serial_data_out_o;
				next_dat[output_serializer_pkg::ST_TRI_BIT] = serial_tristate_out_o;
				next_dat[output_serializer_pkg::ST_FORCE_BIT] = output_force_i;
				next_dat[output_serializer_pkg::ST_CFG_ERR_BIT] = cfg_err;
				next_dat[output_serializer_pkg::ST_ROLE_BIT] = role;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= output_serializer_pkg::CTRL_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	// Word capture on the divided clock; a slave registers its cascade bits on the same edge
	always_comb begin
		next_load_q = divided_clock_i;
		next_data_q = divided_clock_i ? parallel_data_in_i : data_q;
		next_tri_q = divided_clock_i ? parallel_tristate_in_i : tri_q;
		next_cascade = cascade_out_o;
		if (divided_clock_i && role == output_serializer_pkg::ROLE_SLAVE) begin
			next_cascade = parallel_data_in_i[5:2];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			load_q <= 1'b0;
			data_q <= 6'h00;
			tri_q <= 4'h0;
			cascade_out_o <= 4'h0;
		end else begin
			load_q <= next_load_q;
			data_q <= next_data_q;
			tri_q <= next_tri_q;
			cascade_out_o <= next_cascade;
		end
	end

	// Bit 0 leaves first; cascade bits extend the word above input six
	assign data_word = {cascade_in_i, data_q};
	assign master_load = load_q & (role == output_serializer_pkg::ROLE_MASTER);
	// No 3-state path on a slave; a cascaded width blocks the word load but not buffer mode
	assign tri_load = master_load & (data_width <= 4'h6);
	assign tri_tick = (tri_rate == output_serializer_pkg::TRATE_DDR) | rise_tick;
	// Buffer mode follows the pin every cycle, not the word captured on the divided clock
	assign tri_word = (tri_rate == output_serializer_pkg::TRATE_BUF) ? parallel_tristate_in_i
		: tri_q;

	bit_tick tick_gen (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.double_rate_i(data_rate == output_serializer_pkg::RATE_DDR),
		.data_tick_o(data_tick),
		.rise_tick_o(rise_tick)
	);

	word_shifter #(
		.WIDTH(output_serializer_pkg::WORD_MAX),
		.RESET_LEVEL(output_serializer_pkg::DATA_OUT_RESET)
	) data_path (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.width_i(data_width),
		.word_i(data_word),
		.load_i(master_load),
		.tick_i(data_tick),
		.enable_i(data_shift_enable_i),
		.bypass_i(1'b0),
		.force_i(output_force_i),
		.force_level_i(ctrl[output_serializer_pkg::CTRL_FORCE_D_BIT]),
		.init_level_i(ctrl[output_serializer_pkg::CTRL_INIT_D_BIT]),
		.bit_o(serial_data_out_o)
	);

	word_shifter #(
		.WIDTH(output_serializer_pkg::TRI_MAX),
		.RESET_LEVEL(output_serializer_pkg::TRISTATE_OUT_RESET)
	) tristate_path (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.width_i(tri_width),
		.word_i(tri_word),
		.load_i(tri_load),
		.tick_i(tri_tick),
		.enable_i(tristate_shift_enable_i),
		.bypass_i(tri_rate == output_serializer_pkg::TRATE_BUF && role == 1'b0),
		.force_i(output_force_i),
		.force_level_i(ctrl[output_serializer_pkg::CTRL_FORCE_T_BIT]),
		.init_level_i(ctrl[output_serializer_pkg::CTRL_INIT_T_BIT]),
		.bit_o(serial_tristate_out_o)
	);
endmodule : output_serializer

/* verif/output_serializer_properties.sv */
/* Port checker for the output serializer, bound to every instance.
   Assumes CTRL is written with sel[1:0] set; tracks it by watching the bus. */
`timescale 1ns/100ps
module output_serializer_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic divided_clock_i,
	input wire logic [5:0] parallel_data_in_i,
	input wire logic [3:0] parallel_tristate_in_i,
	input wire logic data_shift_enable_i,
	input wire logic tristate_shift_enable_i,
	input wire logic output_force_i,
	input wire logic [3:0] cascade_out_o,
	input wire logic serial_data_out_o,
	input wire logic serial_tristate_out_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o
);
	logic [14:0] ctrl;
	logic [14:0] next_ctrl;
	logic seen;
	logic next_seen;
	always_comb begin
		next_ctrl = ctrl;
		next_seen = (seen || divided_clock_i) && !output_force_i;
		if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00 && &wb_sel_i[1:0]) begin
			next_ctrl = wb_dat_i[14:0];
		end
		if (rst_i) begin
			next_ctrl = 15'h0225;
			next_seen = 1'b0;
		end
	end
	always_ff @(posedge clk_i) begin
		ctrl <= next_ctrl;
		seen <= next_seen;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	reset_clear_a:
		assert property ($fell(rst_i) |-> !serial_data_out_o && !serial_tristate_out_o
		&& cascade_out_o == 4'h0) else $error("reset left outputs set");
	data_freeze_a:
		assert property (!data_shift_enable_i && !output_force_i && !$past(output_force_i)
		&& !$past(output_force_i, 2)
		|=> $stable(serial_data_out_o)) else $error("data moved while disabled");
	tri_freeze_a:
		assert property (!tristate_shift_enable_i && !output_force_i && !$past(output_force_i)
		&& !$past(output_force_i, 2)
		&& ctrl[2:1] != 2'h0 |=> $stable(serial_tristate_out_o)) else $error("tri moved");
	force_level_a:
		assert property (output_force_i |=> serial_data_out_o == $past(ctrl[13])
		&& serial_tristate_out_o == $past(ctrl[14])) else $error("force level wrong");
	buffer_follow_a:
		assert property (seen && ctrl[2:1] == 2'h0 && !ctrl[10] && ctrl[6:3] <= 4'h6
		&& tristate_shift_enable_i && !output_force_i
		|=> serial_tristate_out_o == $past(parallel_tristate_in_i[0])) else $error("no follow");
	slave_pass_a:
		assert property (divided_clock_i && ctrl[10]
		|=> cascade_out_o == $past(parallel_data_in_i[5:2])) else $error("cascade wrong");
	cover property (divided_clock_i && ctrl[10]);
	cover property (output_force_i ##1 !output_force_i);
	cover property (!ctrl[0] && data_shift_enable_i && divided_clock_i);
	cover property (ctrl[6:3] == 4'h8 && data_shift_enable_i && divided_clock_i);
endmodule : output_serializer_checker

bind output_serializer output_serializer_checker checker_inst (.clk_i, .rst_i,
	.divided_clock_i, .parallel_data_in_i, .parallel_tristate_in_i, .data_shift_enable_i,
	.tristate_shift_enable_i, .output_force_i, .cascade_out_o, .serial_data_out_o,
	.serial_tristate_out_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_ack_o);

/* verif/fabric_source.sv */
/* Fabric-side source: divided clock pulses and a stepping word pattern.
   Assumes one pulse every period_i cycles while run_i is high. */
`timescale 1ns/100ps
module fabric_source (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [4:0] period_i,
	output logic pulse_o,
	output logic [5:0] data_o,
	output logic [3:0] tri_o
);
	logic [4:0] count;
	logic [5:0] index;
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			count <= 5'h00;
			index <= 6'h00;
		end else begin
			count <= (count == period_i - 5'h01) ? 5'h00 : count + 5'h01;
			if (pulse_o) begin
				index <= index + 6'h01;
			end
		end
	end
	assign pulse_o = run_i && count == 5'h00;
	assign data_o = index * 6'h07 + 6'h01;
	assign tri_o = index[3:0] ^ 4'h5;
endmodule : fabric_source

/* verif/output_serializer_tb_top.sv */
/* Testbench for the output serializer: bus, stream, force and cascade scenarios.
   Assumes the fabric_source model and the bound port checker. */
`timescale 1ns/100ps
module output_serializer_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic run = 1'b0;
	logic [4:0] period = 5'h04;
	logic data_shift_enable = 1'b0, tristate_shift_enable = 1'b0, force_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0, rdat, bus_out;
	logic pulse, sdo, sto, ack;
	logic [5:0] pdata;
	logic [3:0] ptri, casc;
	int err_total = 0, samples_checked = 0, cycles = 0;
	always #25 clk_i = ~clk_i;
	fabric_source feeder (.clk_i, .rst_i, .run_i(run), .period_i(period), .pulse_o(pulse),
		.data_o(pdata), .tri_o(ptri));
	output_serializer dut (.clk_i, .rst_i, .divided_clock_i(pulse), .parallel_data_in_i(pdata),
		.parallel_tristate_in_i(ptri), .data_shift_enable_i(data_shift_enable), .tristate_shift_enable_i(tristate_shift_enable),
		.output_force_i(force_in), .cascade_in_i(4'hA), .cascade_out_o(casc),
		.serial_data_out_o(sdo), .serial_tristate_out_o(sto), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(bus_out),
		.wb_ack_o(ack));
	task automatic end_of_test();
		if (err_total == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) begin
			@(posedge clk_i);
		end
		rdat = bus_out;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic stream(input logic [31:0] ctl, input int r, input int w);
		logic s [64];
		logic t [64];
		logic [9:0] word;
		logic [3:0] tri_word;
		int hit;
		int bad;
		int tri_hit;
		int tri_bad;
		bus(1'b1, 8'h00, ctl);
		period <= 5'(w * r);
		data_shift_enable <= 1'b1;
		tristate_shift_enable <= 1'b1;
		run <= 1'b1;
		for (int i = 0; i < 64; i++) begin
			@(posedge clk_i);
			s[i] = sdo;
			t[i] = sto;
		end
		hit = 0;
		tri_hit = 0;
		for (int o = 0; o < 64 - 3 * w * r; o++) begin
			bad = 0;
			tri_bad = 0;
			for (int j = 0; j < 3 * w * r; j++) begin
				// Cascade bits stand above the six local inputs
				word = {4'hA, 6'((3 + j / (w * r)) * 7 + 1)};
				tri_word = 4'(3 + j / (w * r)) ^ 4'h5;
				if (s[o + j] !== word[(j / r) % w]) begin
					bad = 1;
				end
				if (t[o + j] !== tri_word[(j / r) % 4]) begin
					tri_bad = 1;
				end
			end
			if (bad == 0) begin
				hit = 1;
			end
			if (tri_bad == 0) begin
				tri_hit = 1;
			end
		end
		check(hit, 1, "serial stream");
		if (w <= 6) begin
			check(tri_hit, 1, "serial tristate");
		end
		data_shift_enable <= 1'b0;
		tristate_shift_enable <= 1'b0;
		repeat (6) @(posedge clk_i);
		run <= 1'b0;
		@(posedge clk_i);
	endtask : stream
	task automatic side_paths();
		logic prev;
		logic [5:0] d;
		bus(1'b1, 8'h00, 32'h0000_00A1);
		run <= 1'b1;
		tristate_shift_enable <= 1'b1;
		repeat (10) @(posedge clk_i);
		prev = ptri[0];
		@(posedge clk_i);
		check(sto, prev, "buffered tri");
		bus(1'b1, 8'h00, 32'h0000_0625);
		while (pulse !== 1'b1) begin
			@(posedge clk_i);
		end
		d = pdata;
		@(posedge clk_i);
		check(casc, d[5:2], "cascade out");
		run <= 1'b0;
		tristate_shift_enable <= 1'b0;
		bus(1'b1, 8'h00, 32'h0000_7225);
		force_in <= 1'b1;
		repeat (2) @(posedge clk_i);
		check({sdo, sto}, 2'h3, "forced levels");
		bus(1'b0, 8'h04, 32'h0);
		check(rdat, 32'h0000_0007, "status forced");
		force_in <= 1'b0;
		repeat (3) @(posedge clk_i);
		check({sdo, sto}, 2'h1, "initial levels");
		force_in <= 1'b1;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		check({sdo, sto}, 2'h0, "reset over force");
		rst_i <= 1'b0;
		force_in <= 1'b0;
		@(posedge clk_i);
	endtask : side_paths
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			end_of_test();
		end
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(1'b0, 8'h00, 32'h0);
		check(rdat, 32'h0000_0225, "ctrl reset");
		bus(1'b0, 8'h0C, 32'h0);
		check(rdat, 32'h0, "unmapped read");
		stream(32'h0000_0225, 1, 4);
		stream(32'h0000_0222, 2, 4);
		stream(32'h0000_0245, 1, 8);
		side_paths();
		end_of_test();
	end
endmodule : output_serializer_tb_top
